// >>> design/dsl_dev.sv
// Converter end: serial capture, hardware reset and converter register load
`timescale 1ns/1ps
module dsl_dev #(
   parameter int unsigned WORD_W = dsl_pkg::WORD_BITS,  // Bits per word
   parameter int unsigned CODE_W = dsl_pkg::CODE_BITS   // Converter code width
) (
   input  wire logic              sys_clk_i,    // System clock
   input  wire logic              rst_n_i,      // Power-on reset, async low
   dsl_link_if.dev                link,         // Link from the host
   input  wire logic              sync_mode_i,  // Strobe taken on clock fall
   output logic [CODE_W-1:0]      dac_code_o,   // Converter register
   output logic [CODE_W-1:0]      input_code_o, // Input holding register
   output logic                   new_data_o,   // Holding register not yet moved
   output logic                   gain_o,       // 1 = gain of 2
   output logic [6:0]             bus_addr_o,   // Two-wire bus address
   output logic                   word_o,       // Pulse: a word was committed
   output logic                   in_reset_o    // Hardware reset pin held
);
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   // Every pin runs three flops deep; a level is taken only once the second
   // and third stages agree, so a glitch one sample wide never reaches the logic.
   // All pins share one pipeline, so data and clock keep their relative timing.
   localparam int unsigned NPIN   = 6;
   localparam int unsigned P_SCLK = 0;
   localparam int unsigned P_SYNC = 1;
   localparam int unsigned P_SDI  = 2;
   localparam int unsigned P_STRB = 3;
   localparam int unsigned P_RST  = 4;
   localparam int unsigned P_ADDR = 5;
   localparam logic [NPIN-1:0] PIN_IDLE = 6'h1b; // Clock, select, strobe, reset high

   // Filter: take the new value only once the last two stages agree
   function automatic logic [NPIN-1:0] settle(input logic [NPIN-1:0] s2,
                                              input logic [NPIN-1:0] s3,
                                              input logic [NPIN-1:0] old);
      settle = (s2 & s3) | (old & (s2 ^ s3));
   endfunction

   // Falling edge of a filtered pin: level held now against the level about
   // to be taken, so the event lines up with the data sampled beside it
   function automatic logic pin_fell(input logic now_v,
                                     input logic next_v);
      pin_fell = now_v & ~next_v;
   endfunction

   logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
   // Pin order matches the position constants above
   wire  [NPIN-1:0] raw = {link.bus_address_pin, link.hw_reset_n, link.load_strobe_n,
                           link.sdi, link.sync_n, link.sclk};
   wire  [NPIN-1:0] pin_d = settle(s2_q, s3_q, pin_q);

   // Three-stage sampling of every pin
   // Reset loads the idle levels, so no false edge follows reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q  <= PIN_IDLE;
         s2_q  <= PIN_IDLE;
         s3_q  <= PIN_IDLE;
         pin_q <= PIN_IDLE;
      end else begin
         s1_q  <= raw;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         pin_q <= pin_d;
      end
   end

   // -------------------------------------------------------------
   // Decoded pin events
   // -------------------------------------------------------------
   // While the reset pin is low every other pin but the address pin is masked off;
   // frame select low opens the clock, data and shifter
   wire hw_rst        = ~pin_q[P_RST];
   wire sel           = ~pin_q[P_SYNC] & ~hw_rst;
   wire sclk_fall_any = pin_fell(pin_q[P_SCLK], pin_d[P_SCLK]);
   wire sclk_fall     = sclk_fall_any & sel;
   wire sync_rise     = pin_fell(~pin_q[P_SYNC], ~pin_d[P_SYNC]) & ~hw_rst;
   wire strobe_low    = ~pin_q[P_STRB] & ~hw_rst;

   // -------------------------------------------------------------
   // Shift register and bit counter
   // -------------------------------------------------------------
   logic [WORD_W-1:0] sh_q;
   logic [4:0]        cnt_q;
   wire  full = (cnt_q == 5'(WORD_W));

   // Shift on each qualified falling edge; counter stops at a full word
   // Extra falls keep shifting, so an overlong frame commits its last bits
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_q  <= '0;
         cnt_q <= 5'h00;
      end else if (hw_rst) begin
         sh_q  <= '0;
         cnt_q <= 5'h00;
      end else if (!sel) begin
         cnt_q <= 5'h00;
      end else if (sclk_fall) begin
         sh_q  <= {sh_q[WORD_W-2:0], pin_q[P_SDI]};
         if (!full) cnt_q <= cnt_q + 5'h01;
      end
   end

   // -------------------------------------------------------------
   // Word decode
   // -------------------------------------------------------------
   // A frame commits only with a full word; unknown commands change nothing
   wire       commit  = sync_rise & full;
   wire [3:0] cmd     = sh_q[dsl_pkg::CMD_MSB:dsl_pkg::CMD_LSB];
   wire       wr_in   = commit & (cmd == dsl_pkg::CMD_WR_INPUT);
   wire       wr_ctrl = commit & (cmd == dsl_pkg::CMD_WR_CTRL);
   wire [CODE_W-1:0] code = sh_q[dsl_pkg::CODE_MSB:dsl_pkg::CODE_LSB];

   // -------------------------------------------------------------
   // Holding, converter and control registers
   // -------------------------------------------------------------
   logic [CODE_W-1:0] in_q, dac_q;
   logic              new_q, gain_q, word_q, rst_seen_q;

   // -------------------------------------------------------------
   // Strobe qualification
   // -------------------------------------------------------------
   // Strobe qualifies on level in async mode, on a clock fall in sync mode;
   // in async mode a strobe held low through a write moves the word once the flag is up
   wire strobe = strobe_low & (~sync_mode_i | sclk_fall_any);
   wire xfer   = strobe & new_q;

   // Holding register and its new-data flag; a write beats a transfer
   // Set wins: a write in the cycle of a transfer leaves the flag up
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_q  <= dsl_pkg::ZERO_SCALE;
         new_q <= 1'b0;
      end else if (hw_rst) begin
         in_q  <= dsl_pkg::ZERO_SCALE;
         new_q <= 1'b0;
      end else if (wr_in) begin
         in_q  <= code;
         new_q <= 1'b1;
      end else if (xfer) begin
         new_q <= 1'b0;
      end
   end

   // Converter register follows the holding register on a transfer;
   // a write alone never reaches it
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) dac_q <= dsl_pkg::ZERO_SCALE;
      else if (hw_rst) dac_q <= dsl_pkg::ZERO_SCALE;
      else if (xfer) dac_q <= in_q;
   end

   // Control register: gain select
   // Gain of 1 stands until a control word says otherwise
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) gain_q <= dsl_pkg::GAIN_DEF;
      else if (hw_rst) gain_q <= dsl_pkg::GAIN_DEF;
      else if (wr_ctrl) gain_q <= sh_q[dsl_pkg::GAIN_BIT];
   end

   // Commit pulse for the user side
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) word_q <= 1'b0;
      else word_q <= commit;
   end

   // Reset pin status for the user side, registered like the other outputs;
   // it changes on the same clock edge as the registers it clears
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) rst_seen_q <= 1'b0;
      else rst_seen_q <= hw_rst;
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // Outputs trail the pins by the filter depth, about four cycles
   assign dac_code_o   = dac_q;
   assign input_code_o = in_q;
   assign new_data_o   = new_q;
   assign gain_o       = gain_q;
   assign word_o       = word_q;
   assign in_reset_o   = rst_seen_q;

   // -------------------------------------------------------------
   // Bus address
   // -------------------------------------------------------------
   // Address pin follows its filtered level at all times, no reset needed
   assign bus_addr_o   = {dsl_pkg::ADDR_BASE, pin_q[P_ADDR]};

endmodule

// >>> design/dsl_host.sv
// Host end: frames 24-bit words, drives the strobe and reset pins
`timescale 1ns/1ps
module dsl_host #(
   parameter int unsigned SCLK_HALF = dsl_pkg::SCLK_HALF_DEF  // Cycles per half period
) (
   input  wire logic        sys_clk_i,    // System clock
   input  wire logic        rst_n_i,      // Async reset, active low
   dsl_link_if.host         link,         // Link to the converter
   input  wire logic        start_i,      // Pulse: send word_i
   input  wire logic [23:0] word_i,       // Word to send, MSB first
   input  wire logic        load_i,       // Pulse: pulse the load strobe
   input  wire logic        strobe_hold_i, // Level: hold the load strobe low
   input  wire logic        hw_reset_i,   // Level: assert hardware reset pin
   input  wire logic        addr_pin_i,   // Level: address pin value
   output logic             busy_o,       // Transfer or strobe in progress
   output logic             done_o        // Pulse: frame closed
);
   // -------------------------------------------------------------
   // States and storage
   // -------------------------------------------------------------
   typedef enum logic [4:0] {
      H_IDLE  = 5'b00001,
      H_LEAD  = 5'b00010,
      H_LOW   = 5'b00100,
      H_HIGH  = 5'b01000,
      H_GAP   = 5'b10000
   } dsl_hstate_e;

   dsl_hstate_e       st_q;
   logic [23:0]       sh_q;         // Bits still to send
   logic [4:0]        bit_q;        // Falling edges given so far
   logic [7:0]        div_q;        // Half period divider
   logic [7:0]        strobe_q;     // Strobe low counter
   logic              sclk_q, sync_n_q, done_q;

   wire tick      = (div_q == 8'(SCLK_HALF - 1)); // Half period elapsed
   wire last_fall = (bit_q == 5'(dsl_pkg::WORD_BITS));

   // Pins
   assign link.sclk            = sclk_q;
   assign link.sync_n          = sync_n_q;
   assign link.sdi             = sh_q[23];
   assign link.load_strobe_n   = ~(strobe_hold_i | (strobe_q != 8'h00));
   assign link.hw_reset_n      = ~hw_reset_i;
   assign link.bus_address_pin = addr_pin_i;
   assign busy_o = (st_q != H_IDLE) | (strobe_q != 8'h00);
   assign done_o = done_q;

   // Divider enable restarts at each state change
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) div_q <= 8'h00;
      else if (st_q == H_IDLE || tick) div_q <= 8'h00;
      else div_q <= div_q + 8'h01;
   end

   // Load strobe pulse of the least allowed width
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) strobe_q <= 8'h00;
      else if (load_i && strobe_q == 8'h00 && st_q == H_IDLE)
         strobe_q <= 8'(dsl_pkg::STROBE_LOW_CYC);
      else if (strobe_q != 8'h00) strobe_q <= strobe_q - 8'h01;
   end

   // Frame sequencer: bit set up while clock high, taken on its fall
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q     <= H_IDLE;
         sh_q     <= 24'h000000;
         bit_q    <= 5'h00;
         sclk_q   <= 1'b1;
         sync_n_q <= 1'b1;
         done_q   <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            H_IDLE: if (start_i && strobe_q == 8'h00) begin
               sh_q     <= word_i;
               bit_q    <= 5'h00;
               sync_n_q <= 1'b0;
               st_q     <= H_LEAD;
            end
            H_LEAD: if (tick) begin
               sclk_q <= 1'b0;
               bit_q  <= bit_q + 5'h01;
               st_q   <= H_LOW;
            end
            H_LOW: if (tick) begin
               if (last_fall) begin
                  sync_n_q <= 1'b1;
                  done_q   <= 1'b1;
                  st_q     <= H_GAP;
               end else begin
                  sclk_q <= 1'b1;
                  sh_q   <= {sh_q[22:0], 1'b0};
                  st_q   <= H_HIGH;
               end
            end
            H_HIGH: if (tick) begin
               sclk_q <= 1'b0;
               bit_q  <= bit_q + 5'h01;
               st_q   <= H_LOW;
            end
            H_GAP: if (tick) begin
               sclk_q <= 1'b1;
               st_q   <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end
endmodule

// >>> design/dsl_link_if.sv
// Link wires between the host end and the converter end
`timescale 1ns/1ps
interface dsl_link_if;
   logic sclk;           // Serial clock, host made
   logic sync_n;         // Frame select, low opens a transfer
   logic sdi;            // Serial data toward the converter
   logic load_strobe_n;  // Load strobe, low transfers holding to converter
   logic hw_reset_n;     // Hardware reset pin, low holds reset
   logic bus_address_pin; // Address pin for the two-wire variant

   modport host (
      output sclk, sync_n, sdi, load_strobe_n, hw_reset_n, bus_address_pin
   );
   modport dev (
      input  sclk, sync_n, sdi, load_strobe_n, hw_reset_n, bus_address_pin
   );
endinterface

// >>> design/dsl_pkg.sv
// Shared constants for the serial load control block, both ends
package dsl_pkg;

   // -------------------------------------------------------------
   // Word layout
   // -------------------------------------------------------------
   localparam int unsigned WORD_BITS  = 24;     // One write is one 24-bit word
   localparam int unsigned CNT_W      = 5;      // Width of the bit counter
   localparam int unsigned CODE_BITS  = 10;     // Converter code width
   localparam int unsigned CMD_MSB    = 23;     // Command nibble top bit
   localparam int unsigned CMD_LSB    = 20;     // Command nibble bottom bit
   localparam int unsigned CODE_MSB   = 15;     // Code field, left justified
   localparam int unsigned CODE_LSB   = 6;      // Code field bottom bit
   localparam int unsigned GAIN_BIT   = 11;     // Gain select in control word

   // -------------------------------------------------------------
   // Commands and reset values
   // -------------------------------------------------------------
   localparam logic [3:0] CMD_WR_INPUT = 4'h1;  // Write input holding register
   localparam logic [3:0] CMD_WR_CTRL  = 4'h4;  // Write control register
   localparam logic [9:0] ZERO_SCALE   = 10'h000; // Zero-scale code
   localparam logic       GAIN_DEF     = 1'b0;  // 0 = gain of 1, 1 = gain of 2

   // -------------------------------------------------------------
   // Bus address and timing
   // -------------------------------------------------------------
   localparam logic [5:0] ADDR_BASE    = 6'h0c; // Upper address bits, arbitrary value
   localparam int unsigned SYS_MHZ     = 100;   // System clock rate
   localparam int unsigned SCLK_MAX_MHZ = 50;   // Fastest serial clock accepted
   localparam int unsigned STROBE_LOW_NS = 20;  // Least load strobe low width
   localparam int unsigned SYNC_HIGH_NS = 20;   // Least frame select high time
   localparam int unsigned STROBE_LOW_CYC =
      (STROBE_LOW_NS * SYS_MHZ + 999) / 1000;   // Rounded up to cycles
   localparam int unsigned SYNC_HIGH_CYC =
      (SYNC_HIGH_NS * SYS_MHZ + 999) / 1000;    // Rounded up to cycles
   localparam int unsigned SCLK_HALF_DEF = 4;   // Host half period: 80 ns clock

endpackage

// >>> test/dac_serial_load_control_test.sv
// Self-checking bench for both ends of the serial load link
`timescale 1ns/1ps
module dac_serial_load_control_test;
   logic        sys_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic        start     = 1'b0;
   logic [23:0] word      = 24'h000000;
   logic        load      = 1'b0;
   logic        strobe_hold = 1'b0;
   logic        hw_reset  = 1'b0;
   logic        addr_pin  = 1'b0;
   logic        sync_mode = 1'b0;
   logic        done;
   logic [9:0]  dac_code;
   logic [9:0]  input_code;
   logic        new_data;
   logic        gain;
   logic [6:0]  bus_addr;
   logic        in_reset;
   int          err_count   = 0;
   int          check_count = 0;
   int          cyc         = 0;

   // Both ends face each other over one link
   dsl_link_if link_if ();
   dsl_host dsl_host_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(link_if),
      .start_i(start), .word_i(word), .load_i(load), .strobe_hold_i(strobe_hold),
      .hw_reset_i(hw_reset), .addr_pin_i(addr_pin), .busy_o(), .done_o(done));
   dsl_dev dsl_dev_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .link(link_if),
      .sync_mode_i(sync_mode), .dac_code_o(dac_code), .input_code_o(input_code),
      .new_data_o(new_data), .gain_o(gain), .bus_addr_o(bus_addr), .word_o(),
      .in_reset_o(in_reset));
   dsl_properties dsl_properties_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .sclk(link_if.sclk), .sync_n(link_if.sync_n), .sdi(link_if.sdi),
      .load_strobe_n(link_if.load_strobe_n));

   // Clock and hang guard
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   function automatic logic [23:0] wr(input logic [9:0] code);
      return {dsl_pkg::CMD_WR_INPUT, 4'h0, code, 6'h00};
   endfunction
   function automatic logic [23:0] ctl(input logic g);
      return {dsl_pkg::CMD_WR_CTRL, 8'h00, g, 11'h000};
   endfunction
   task automatic send(input logic [23:0] w);
      int n;
      n = 0;
      start = 1'b1;
      word = w;
      tick(1);
      start = 1'b0;
      while (done !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      chk(10'(n < 400), 10'h001, "frame closed");
      tick(8);
   endtask
   task automatic pulse();
      load = 1'b1;
      tick(1);
      load = 1'b0;
      tick(8);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk(dac_code, 10'h000, "power-on code");
      chk(10'(gain), 10'h000, "power-on gain");
      for (int a = 0; a < 2; a++) begin
         addr_pin = a[0];
         tick(5);
         chk(10'(bus_addr), 10'({dsl_pkg::ADDR_BASE, a[0]}), "bus address");
      end
      $display("test reset done");
   endtask
   task automatic t_strobe();
      send(wr(10'h3a5));
      chk(input_code, 10'h3a5, "holding code");
      chk(dac_code, 10'h000, "code before strobe");
      chk(10'(new_data), 10'h001, "new flag set");
      pulse();
      chk(dac_code, 10'h3a5, "code after strobe");
      chk(10'(new_data), 10'h000, "new flag cleared");
      send(ctl(1'b1));
      chk(10'(gain), 10'h001, "gain of 2");
      pulse();
      chk(dac_code, 10'h3a5, "stale strobe");
      send(ctl(1'b0));
      chk(10'(gain), 10'h000, "gain of 1");
      $display("test strobe done");
   endtask
   task automatic t_auto();
      strobe_hold = 1'b1;
      tick(1);
      send(wr(10'h2ff));
      chk(dac_code, 10'h2ff, "held strobe load");
      chk(10'(new_data), 10'h000, "held strobe flag");
      strobe_hold = 1'b0;
      tick(4);
      $display("test auto load done");
   endtask
   task automatic t_sync();
      sync_mode = 1'b1;
      send(wr(10'h0aa));
      pulse();
      chk(dac_code, 10'h2ff, "no clock, no load");
      strobe_hold = 1'b1;
      tick(1);
      send(ctl(1'b0));
      strobe_hold = 1'b0;
      chk(dac_code, 10'h0aa, "clocked load");
      sync_mode = 1'b0;
      tick(4);
      $display("test sync mode done");
   endtask
   task automatic t_hwrst();
      send(ctl(1'b1));
      hw_reset = 1'b1;
      tick(8);
      chk(10'(in_reset), 10'h001, "in reset");
      chk(dac_code, 10'h000, "reset code");
      chk(10'(gain), 10'h000, "reset gain");
      send(wr(10'h155));
      chk(input_code, 10'h000, "frame ignored");
      hw_reset = 1'b0;
      tick(8);
      chk(10'(in_reset), 10'h000, "out of reset");
      send(wr(10'h155));
      chk(input_code, 10'h155, "write after reset");
      chk(dac_code, 10'h000, "no load yet");
      pulse();
      chk(dac_code, 10'h155, "load after reset");
      rst_n = 1'b0;
      tick(2);
      chk(dac_code, 10'h000, "power-on code again");
      chk(input_code, 10'h000, "power-on holding again");
      rst_n = 1'b1;
      tick(4);
      $display("test hardware reset done");
   endtask

   // Verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      tick(1);
      t_reset();
      t_strobe();
      t_auto();
      t_sync();
      t_hwrst();
      give_verdict();
   end
endmodule

// >>> test/dsl_properties.sv
// Checker for the link wires between host and converter ends
`timescale 1ns/1ps
module dsl_properties (
   input wire logic sys_clk_i,     // Clock
   input wire logic rst_n_i,       // Reset, active low
   input wire logic sclk,          // Serial clock
   input wire logic sync_n,        // Frame select
   input wire logic sdi,           // Serial data
   input wire logic load_strobe_n  // Load strobe
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   // ------------------------------------------------------------
   // Count serial clock falls inside the open frame
   // ------------------------------------------------------------
   logic       sclk_q;
   logic [4:0] falls_q;
   logic [4:0] falls_d;
   assign falls_d = sync_n ? 5'h00 : falls_q + {4'h0, sclk_q & ~sclk};
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_q  <= 1'b1;
         falls_q <= 5'h00;
      end else begin
         sclk_q  <= sclk;
         falls_q <= falls_d;
      end
   end

   // ------------------------------------------------------------
   // Link timing and framing
   // ------------------------------------------------------------
   property p_sclk_idle; sync_n [*5] |-> sclk; endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("serial clock not idle high between frames");
   property p_sclk_quiet; sync_n && $past(sync_n) |-> !$fell(sclk); endproperty
   a_sclk_quiet: assert property (p_sclk_quiet)
      else $error("serial clock fell outside a frame");
   property p_sdi_hold; $fell(sclk) |-> $stable(sdi) ##1 $stable(sdi); endproperty
   a_sdi_hold: assert property (p_sdi_hold)
      else $error("data moved at the sampling fall");
   property p_sclk_low; $fell(sclk) |-> !sclk [*4] ##1 (sclk || sync_n); endproperty
   a_sclk_low: assert property (p_sclk_low)
      else $error("serial clock low time wrong");
   property p_sclk_high; $rose(sclk) && !sync_n |-> sclk [*4]; endproperty
   a_sclk_high: assert property (p_sclk_high)
      else $error("serial clock high time too short");
   property p_sync_gap; $rose(sync_n) |-> sync_n [*4]; endproperty
   a_sync_gap: assert property (p_sync_gap)
      else $error("frame select high gap too short");
   property p_sync_setup; $fell(sync_n) |-> sclk [*4]; endproperty
   a_sync_setup: assert property (p_sync_setup)
      else $error("clock fell too soon after frame open");
   property p_frame_bits; $rose(sync_n) |-> falls_q == 5'h18; endproperty
   a_frame_bits: assert property (p_frame_bits)
      else $error("frame closed without 24 clock falls");
   property p_strobe_width; $fell(load_strobe_n) |-> !load_strobe_n [*2]; endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("load strobe pulse too short");

   // Main scenarios seen
   c_frame: cover property ($rose(sync_n) && falls_q == 5'h18);
   c_pulse: cover property ($fell(load_strobe_n) ##2 load_strobe_n);
   c_hold: cover property (!load_strobe_n [*8]);
endmodule
